// File: src/fpc_cfg.svh
// Constants for the flash protection and power controller
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
// Register word offsets (byte addresses)
`define FPC_REG_CTRL 12'h000
`define FPC_REG_ADDR 12'h004
`define FPC_REG_DATA 12'h008
`define FPC_REG_STAT 12'h00C
`define FPC_REG_RDAT 12'h010
// Control fields
`define FPC_CTRL_GO 0
`define FPC_CTRL_PDN 1
`define FPC_CTRL_OP_LO 4
`define FPC_CTRL_OP_HI 6
// Operations
`define FPC_OP_PROT_PROG 3'h0
`define FPC_OP_READ_CFG 3'h1
`define FPC_OP_READ_ARRAY 3'h2
`define FPC_OP_READ_STAT 3'h3
`define FPC_OP_READ 3'h4
`define FPC_OP_LOCK_USER 3'h5
// Flash command codes
`define FPC_CMD_PROT_SETUP 16'h00C0
`define FPC_CMD_READ_CFG 16'h0090
`define FPC_CMD_READ_ARRAY 16'h00FF
`define FPC_CMD_READ_STAT 16'h0070
`define FPC_CMD_CLR_STAT 16'h0050
`define FPC_LOCK_VALUE 16'hFFFD
// Lock word address (parameter-like default)
`define FPC_LOCK_ADDR 21'h000080
// Status bits of the flash
`define FPC_SR_READY 7
`define FPC_SR_PROG_ERR 4
`define FPC_SR_SUPPLY_ERR 3
`define FPC_SR_LOCK_ERR 1
// Bus strobe timing in clocks of 100 ns
`define FPC_CLK_NS 100
`define FPC_STROBE_NS 100
`define FPC_STROBE_CYC ((`FPC_STROBE_NS+`FPC_CLK_NS-1)/`FPC_CLK_NS)
// Recovery after power-down release (reads, writes)
`define FPC_REC_RD_NS 200
`define FPC_REC_WR_NS 300
`define FPC_REC_RD_CYC ((`FPC_REC_RD_NS+`FPC_CLK_NS-1)/`FPC_CLK_NS)
`define FPC_REC_WR_CYC ((`FPC_REC_WR_NS+`FPC_CLK_NS-1)/`FPC_CLK_NS)
`define FPC_CNT_W 4
`endif

// File: src/fpc_pkg.sv
// Types for the flash protection and power controller
package fpc_pkg;
	typedef enum logic [8:0] {
		FPC_IDLE = 9'h001,
		FPC_WR1 = 9'h002,
		FPC_GAP1 = 9'h004,
		FPC_WR2 = 9'h008,
		FPC_GAP2 = 9'h010,
		FPC_POLL = 9'h020,
		FPC_RD = 9'h040,
		FPC_PDN = 9'h080,
		FPC_REC = 9'h100
	} fpc_state_e;
	typedef logic [3:0] fpc_cnt_t;
endpackage

// File: src/fpc_strobe.sv
// Bus strobe timer for flash write and read cycles
`timescale 1ns/1ns
`include "fpc_cfg.svh"
module fpc_strobe
	import fpc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	input wire logic [`FPC_CNT_W-1:0] len,
	output logic busy,
	output logic done
);
	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	fpc_cnt_t cnt_q, cnt_d;
	logic done_q, done_d;

	// Next count
	always_comb begin
		cnt_d = cnt_q;
		done_d = 1'b0;
		if (start) begin
			cnt_d = len;
		end else if (cnt_q != 4'h0) begin
			cnt_d = cnt_q - 4'h1;
			done_d = (cnt_q == 4'h1);
		end
	end

	// Register count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 4'h0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			done_q <= done_d;
		end
	end

	assign busy = (cnt_q != 4'h0);
	assign done = done_q;
endmodule

// File: src/fpc_top.sv
// Host controller driving a parallel flash's protection and power pins
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ns
`include "fpc_cfg.svh"
module fpc_top
	import fpc_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Flash pins
	output logic [20:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic powerdown_reset_n
);
	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	fpc_state_e st_q, st_d;
	logic [2:0] op_q, op_d;
	logic pdn_q, pdn_d;
	logic [20:0] addr_q, addr_d;
	logic [15:0] data_q, data_d;
	logic [15:0] rdat_q, rdat_d;
	logic [7:0] sr_q, sr_d;
	logic done_q, done_d;
	logic [20:0] fa_q, fa_d;
	logic [15:0] fdo_q, fdo_d;
	logic foe_q, foe_d, ce_n_q, ce_n_d, oe_n_q, oe_n_d;
	logic we_n_q, we_n_d, rp_n_q, rp_n_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [`FPC_CNT_W-1:0] rec_q, rec_d;
	logic stb_start;
	logic [`FPC_CNT_W-1:0] stb_len;
	logic stb_busy, stb_done;
	logic acc, wr_go, wr_pdn;

	// Strobe timer
	fpc_strobe u_strobe (
		.pclk(pclk),
		.presetn(presetn),
		.start(stb_start),
		.len(stb_len),
		.busy(stb_busy),
		.done(stb_done)
	);

	assign acc = psel && penable && !pready_q;
	assign wr_go = acc && pwrite && (paddr == `FPC_REG_CTRL)
		&& pwdata[`FPC_CTRL_GO];
	assign wr_pdn = acc && pwrite && (paddr == `FPC_REG_CTRL);

	// ------------------------------------------------------------
	// APB slave, one wait state
	// ------------------------------------------------------------
	always_comb begin
		pready_d = acc;
		pslverr_d = 1'b0;
		prdata_d = 32'h0000_0000;
		addr_d = addr_q;
		data_d = data_q;
		if (acc) begin
			case (paddr)
				`FPC_REG_CTRL: prdata_d = {25'h0, op_q, 3'h0, pdn_q};
				`FPC_REG_ADDR: begin
					prdata_d = {11'h0, addr_q};
					if (pwrite) addr_d = pwdata[20:0];
				end
				`FPC_REG_DATA: begin
					prdata_d = {16'h0, data_q};
					if (pwrite) data_d = pwdata[15:0];
				end
				`FPC_REG_STAT: prdata_d = {st_q == FPC_IDLE,
					done_q, 22'h0, sr_q};
				`FPC_REG_RDAT: prdata_d = {16'h0, rdat_q};
				default: pslverr_d = 1'b1;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flash sequencer
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		pdn_d = pdn_q;
		rdat_d = rdat_q;
		sr_d = sr_q;
		done_d = done_q;
		fa_d = fa_q;
		fdo_d = fdo_q;
		foe_d = foe_q;
		ce_n_d = ce_n_q;
		oe_n_d = oe_n_q;
		we_n_d = we_n_q;
		rp_n_d = rp_n_q;
		rec_d = rec_q;
		stb_start = 1'b0;
		stb_len = fpc_cnt_t'(`FPC_STROBE_CYC);
		if (wr_pdn) pdn_d = pwdata[`FPC_CTRL_PDN];
		if (wr_go) done_d = 1'b0;
		case (st_q)
			FPC_IDLE: begin
				ce_n_d = 1'b1;
				if (pdn_q) begin
					rp_n_d = 1'b0;
					sr_d = 8'h00;
					st_d = FPC_PDN;
				end else if (wr_go) begin
					op_d = pwdata[`FPC_CTRL_OP_HI:`FPC_CTRL_OP_LO];
					fa_d = addr_q;
					ce_n_d = 1'b0;
					foe_d = 1'b1;
					stb_start = 1'b1;
					case (pwdata[`FPC_CTRL_OP_HI:`FPC_CTRL_OP_LO])
						`FPC_OP_PROT_PROG, `FPC_OP_LOCK_USER: begin
							fdo_d = `FPC_CMD_PROT_SETUP;
							we_n_d = 1'b0;
							st_d = FPC_WR1;
						end
						`FPC_OP_READ_CFG: begin
							fdo_d = `FPC_CMD_READ_CFG;
							we_n_d = 1'b0;
							st_d = FPC_WR2;
						end
						`FPC_OP_READ_ARRAY: begin
							fdo_d = `FPC_CMD_READ_ARRAY;
							we_n_d = 1'b0;
							st_d = FPC_WR2;
						end
						`FPC_OP_READ_STAT: begin
							fdo_d = `FPC_CMD_READ_STAT;
							we_n_d = 1'b0;
							st_d = FPC_WR2;
						end
						default: begin
							foe_d = 1'b0;
							oe_n_d = 1'b0;
							st_d = FPC_RD;
						end
					endcase
				end
			end
			FPC_WR1: if (stb_done) begin
				we_n_d = 1'b1;
				st_d = FPC_GAP1;
			end
			FPC_GAP1: begin
				// Second write carries the target word
				if (op_q == `FPC_OP_LOCK_USER) begin
					fa_d = `FPC_LOCK_ADDR;
					fdo_d = `FPC_LOCK_VALUE;
				end else begin
					fdo_d = data_q;
				end
				we_n_d = 1'b0;
				stb_start = 1'b1;
				st_d = FPC_WR2;
			end
			FPC_WR2: if (stb_done) begin
				we_n_d = 1'b1;
				st_d = FPC_GAP2;
			end
			FPC_GAP2: begin
				foe_d = 1'b0;
				if (op_q == `FPC_OP_PROT_PROG
					|| op_q == `FPC_OP_LOCK_USER) begin
					oe_n_d = 1'b0;
					stb_start = 1'b1;
					st_d = FPC_POLL;
				end else begin
					done_d = 1'b1;
					st_d = FPC_IDLE;
				end
			end
			FPC_POLL: if (stb_done) begin
				if (flash_dq_in[`FPC_SR_READY]) begin
					// Errors
					sr_d = flash_dq_in[7:0];
					oe_n_d = 1'b1;
					done_d = 1'b1;
					st_d = FPC_IDLE;
				end else begin
					stb_start = 1'b1;
				end
			end
			FPC_RD: if (stb_done) begin
				rdat_d = flash_dq_in;
				oe_n_d = 1'b1;
				done_d = 1'b1;
				st_d = FPC_IDLE;
			end
			FPC_PDN: begin
				ce_n_d = 1'b1;
				if (!pdn_q) begin
					rp_n_d = 1'b1;
					rec_d = fpc_cnt_t'(`FPC_REC_WR_CYC);
					st_d = FPC_REC;
				end
			end
			FPC_REC: begin
				// Flash released; no access until the count runs out
				rp_n_d = 1'b1;
				if (rec_q != 4'h0) rec_d = rec_q - 4'h1;
				else st_d = FPC_IDLE;
			end
			default: st_d = FPC_IDLE;
		endcase
	end

	// Register everything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= FPC_REC; // Wake through recovery after reset
			op_q <= 3'h0;
			pdn_q <= 1'b0;
			addr_q <= 21'h000000;
			data_q <= 16'h0000;
			rdat_q <= 16'h0000;
			sr_q <= 8'h00;
			done_q <= 1'b0;
			fa_q <= 21'h000000;
			fdo_q <= 16'h0000;
			foe_q <= 1'b0;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			rp_n_q <= 1'b0;
			rec_q <= fpc_cnt_t'(`FPC_REC_WR_CYC);
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			pdn_q <= pdn_d;
			addr_q <= addr_d;
			data_q <= data_d;
			rdat_q <= rdat_d;
			sr_q <= sr_d;
			done_q <= done_d;
			fa_q <= fa_d;
			fdo_q <= fdo_d;
			foe_q <= foe_d;
			ce_n_q <= ce_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			rp_n_q <= rp_n_d;
			rec_q <= rec_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign flash_addr = fa_q;
	assign flash_dq_out = fdo_q;
	assign flash_dq_oe = foe_q;
	assign flash_ce_n = ce_n_q;
	assign flash_oe_n = oe_n_q;
	assign flash_we_n = we_n_q;
	assign powerdown_reset_n = rp_n_q;
endmodule

// File: bench/fpc_top_properties.sv
// Protocol checks on the controller's bus and flash pins
`timescale 1ns/1ns
module fpc_top_properties (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// Flash pins
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic powerdown_reset_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answers
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	// Flash strobes
	a_we_select: assert property (
		!flash_we_n |-> !flash_ce_n && flash_dq_oe)
		else $error("write without select");
	a_we_pulse: assert property (
		$fell(flash_we_n) |=> !flash_we_n ##1 flash_we_n)
		else $error("write strobe length");
	a_setup_pair: assert property (
		$fell(flash_we_n) && flash_dq_out == 16'h00C0 |-> ##3 $fell(flash_we_n))
		else $error("setup not followed");
	a_no_fight: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("bus contention");
	a_pdn_quiet: assert property (
		!powerdown_reset_n |-> flash_ce_n && flash_we_n && flash_oe_n)
		else $error("strobes in power-down");
	a_recovery: assert property (
		$rose(powerdown_reset_n) |-> flash_ce_n [*3])
		else $error("access too soon");
	// Main scenarios
	c_setup: cover property ($fell(flash_we_n) && flash_dq_out == 16'h00C0);
	c_err: cover property (pslverr);
	c_wake: cover property ($rose(powerdown_reset_n));
endmodule
bind fpc_top fpc_top_properties u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
	.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
	.flash_we_n(flash_we_n), .powerdown_reset_n(powerdown_reset_n));

// File: bench/fpc_flash_model.sv
// Behavioural flash device with protection words and status
`timescale 1ns/1ns
module fpc_flash_model (
	// Pins from controller
	input wire logic [20:0] addr,
	input wire logic [15:0] dq,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic rp_n,
	// Supply condition
	input wire logic vpp_low,
	// Data to controller
	output logic [15:0] dq_q
);
	logic [15:0] prot [0:8];
	logic [15:0] last;
	logic [7:0] sr;
	logic [1:0] mode;
	logic setup;
	logic seg;
	wire drive = !ce_n && !oe_n && rp_n;
	wire [15:0] val = mode == 2'h2 ? {8'h00, sr} :
		mode == 2'h1 ? prot[addr[3:0]] : ~addr[15:0];
	// Blank words, factory bit already cleared
	initial begin
		last = 16'h0000;
		for (int i = 0; i < 9; i++) prot[i] = 16'hFFFF;
		prot[0] = 16'hFFFE;
	end
	assign seg = addr == 21'h80 || addr > 21'h84;
	// Command decode on write strobe rise
	always @(posedge we_n or negedge rp_n) begin
		// Power-down drops a pending setup and clears status
		if (!rp_n) begin
			sr <= 8'h80;
			mode <= 2'h0;
			setup <= 1'b0;
		end else if (!ce_n) begin
			if (setup) begin
				setup <= 1'b0;
				mode <= 2'h2;
				if (vpp_low) sr <= sr | 8'h08;
				else if (addr < 21'h80 || addr > 21'h88) sr <= sr | 8'h10;
				else if (!prot[0][seg]) sr <= sr | 8'h12;
				// Completes regardless of a later chip select rise
				else prot[addr[3:0]] <= prot[addr[3:0]] & dq;
			end else begin
				case (dq[7:0])
					8'hC0: begin setup <= 1'b1; mode <= 2'h2; end
					8'h90: mode <= 2'h1;
					8'hFF: mode <= 2'h0;
					8'h70: mode <= 2'h2;
					8'h50: sr <= 8'h80;
					default: ;
				endcase
			end
		end
	end
	// Released bus shows inverse of last driven value
	always @* if (drive) last = val;
	assign dq_q = drive ? val : ~last;
endmodule

// File: bench/flash_protection_and_power_control_bench.sv
// Self-checking bench for the flash protection and power controller
`timescale 1ns/1ns
`include "fpc_cfg.svh"
module flash_protection_and_power_control_bench;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, vpp_low = 1'b0, pready, pslverr, er;
	logic dq_oe, ce_n, oe_n, we_n, rp_n;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [20:0] fa;
	logic [15:0] dq_out, dq_in;
	int miscompares = 0, checked = 0;
	// Clock and parts
	always #50 pclk = ~pclk;
	fpc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa),
		.flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
		.flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.powerdown_reset_n(rp_n));
	fpc_flash_model u_flash (.addr(fa), .dq(dq_out), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .rp_n(rp_n), .vpp_low(vpp_low),
		.dq_q(dq_in));
	task automatic report_and_stop;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Pready sampled at rising edges, data taken at that edge
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		rd = prdata;
		er = pslverr;
		if (n >= 50) cmp(32'h0, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_stat(input int b);
		int n;
		n = 0;
		do apb(1'b0, `FPC_REG_STAT, 32'h0); while (rd[b] !== 1'b1 && ++n < 40);
		if (n >= 40) cmp(rd, 32'hFFFFFFFF);
	endtask
	task automatic op(input logic [2:0] c, input logic [20:0] a,
		input logic [15:0] d);
		apb(1'b1, `FPC_REG_ADDR, {11'h0, a});
		apb(1'b1, `FPC_REG_DATA, {16'h0, d});
		apb(1'b1, `FPC_REG_CTRL, {25'h0, c, 4'h1});
		wait_stat(30);
	endtask
	task automatic rd_word(input logic [2:0] m, input logic [20:0] a);
		op(m, 21'h0, 16'h0);
		op(`FPC_OP_READ, a, 16'h0);
		apb(1'b0, `FPC_REG_RDAT, 32'h0);
	endtask
	task automatic stat_is(input logic [7:0] e);
		apb(1'b0, `FPC_REG_STAT, 32'h0);
		cmp({24'h0, rd[7:0]}, {24'h0, e});
	endtask
	// Power-down, status cleared, then wake
	task automatic t_pdn;
		apb(1'b1, `FPC_REG_CTRL, 32'h2);
		cmp({31'h0, rp_n}, 32'h0);
		stat_is(8'h00);
		apb(1'b1, `FPC_REG_CTRL, 32'h0);
		wait_stat(31);
	endtask
	task automatic t_basic;
		wait_stat(31);
		cmp({31'h0, rp_n}, 32'h1);
		apb(1'b0, 12'hFFC, 32'h0);
		cmp({31'h0, er}, 32'h1);
		op(`FPC_OP_READ, 21'h1234, 16'h0);
		apb(1'b0, `FPC_REG_RDAT, 32'h0);
		cmp(rd, 32'hEDCB);
	endtask
	task automatic t_prog;
		op(`FPC_OP_PROT_PROG, 21'h85, 16'h1234);
		stat_is(8'h80);
		rd_word(`FPC_OP_READ_CFG, 21'h85);
		cmp(rd, 32'h1234);
		rd_word(`FPC_OP_READ_ARRAY, 21'h85);
		cmp(rd, 32'hFF7A);
		rd_word(`FPC_OP_READ_STAT, 21'h0);
		cmp(rd, 32'h0080);
	endtask
	// Outside address, factory segment, low supply
	task automatic t_errs;
		logic [20:0] a [3] = '{21'h90, 21'h81, 21'h86};
		logic [7:0] e [3] = '{8'h90, 8'h92, 8'h88};
		for (int i = 0; i < 3; i++) begin
			t_pdn;
			vpp_low <= i == 2;
			op(`FPC_OP_PROT_PROG, a[i], 16'h0);
			stat_is(e[i]);
		end
		vpp_low <= 1'b0;
	endtask
	task automatic t_lock;
		t_pdn;
		op(`FPC_OP_LOCK_USER, 21'h0, 16'h0);
		rd_word(`FPC_OP_READ_CFG, 21'h80);
		cmp(rd, 32'hFFFC);
		op(`FPC_OP_PROT_PROG, 21'h85, 16'h0);
		stat_is(8'h92);
		t_pdn;
		rd_word(`FPC_OP_READ_CFG, 21'h85);
		cmp(rd, 32'h1234);
	endtask
	// Watchdog
	initial begin
		#2000000;
		miscompares++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_basic;
		t_prog;
		t_errs;
		t_lock;
		report_and_stop;
	end
endmodule
